// >>> logic/dcr_ctrl.sv
// Reset, divider, valid strobe, overrange flag and ratio select control.
// Assumes the modulator and filter datapaths sit outside and are steered
// by the enables and reset driven here.
//
// Function
// RQ1: Reset input is active low and acts asynchronously.
// RQ2: In reset the filter clock stops and the valid strobe is low.
// RQ3: Modulator and dividers are cleared and held while reset is low.
// RQ4: Other party holds reset low at least one converter period.
// RQ5: Dividers restart on next falling edge; strobe rises about 15 ns later.
// RQ6: Reset leaves filter contents untouched.
// RQ7: Consumer discards 321 samples after reset or switch in 8x; the host model flushes after reset only.
// RQ8: Consumer discards 108 samples in 4x, 23 samples in 2x.
// RQ9: Controller resets all converters together to align dividers.
// RQ10: Overrange flag updates once per converter period.
// RQ11: Consumer samples the overrange flag on the falling edge.
// RQ12: Modulator detector flags and clips beyond 3% over full scale.
// RQ13: Modulator overrange shows 3 1/2 periods after the sampling edge.
// RQ14: Post-filter detector flags and clips filter output to full scale.
// RQ15: Overrange flag is the OR of both detectors.
// RQ16: Mode bands select 8x, 2x, 4x, 1x from lowest to highest.
// RQ17: Encoded mode selection is latched on the falling edge.
// RQ18: Sample outputs change with the strobe rising edge.
// RQ19: Strobe runs near half duty, independent of read and select.
// RQ20: Samples are signed twos complement words.
// RQ21: One sample and strobe period per ratio converter periods.
`timescale 1ns/10ps
`default_nettype none

module dcr_ctrl
  import dcr_pkg::*;
(
  // Clock and reset
  input  wire logic                       CORE_CLK_IN,
  input  wire logic                       RSTN_IN,
  // Mode comparators, thermometer code from lowest threshold up
  input  wire logic [2:0]                 MODE_CMP_IN,
  // Datapath taps
  input  wire logic signed [MOD_W-1:0]    MOD_DATA_IN,
  input  wire logic signed [FILT_W-1:0]   FILT_DATA_IN,
  // Output control
  input  wire logic                       CS_N_IN,
  input  wire logic                       READ_IN,
  // Converter clock and datapath control
  output logic                            CONV_CLK_OUT,
  output logic                            MOD_RST_OUT,
  output logic                            FILT_CLK_EN_OUT,
  output logic signed [MOD_W-1:0]         MOD_CLIP_OUT,
  // Host side
  output logic                            OUTPUT_VALID_STROBE_OUT,
  output logic signed [SAMPLE_W-1:0]      SAMPLE_OUTPUT_BITS_OUT,
  output logic                            SAMPLE_OE_OUT,
  output logic                            OVERRANGE_FLAG_OUT,
  output logic [1:0]                      RATIO_OUT
);

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  function automatic dcr_ratio_e encode_mode(input logic [2:0] cmp);
    unique case (cmp)
      3'b000:  encode_mode = DCR_X8;
      3'b001:  encode_mode = DCR_X2;
      3'b011:  encode_mode = DCR_X4;
      3'b111:  encode_mode = DCR_X1;
      default: encode_mode = DCR_X8;
    endcase
  endfunction : encode_mode

  function automatic logic [CNT_W:0] period_cyc(input dcr_ratio_e r);
    unique case (r)
      DCR_X1: period_cyc = 5'h02;
      DCR_X2: period_cyc = 5'h04;
      DCR_X4: period_cyc = 5'h08;
      DCR_X8: period_cyc = 5'h10;
    endcase
  endfunction : period_cyc

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                   phase;
  logic                   running;
  logic [CNT_W-1:0]       cnt;
  logic                   strobe;
  dcr_ratio_e             ratio;
  dcr_sample_s            sample;
  logic [OVR_STAGES-1:0]  mod_ovr_pipe;
  logic                   ovr_flag;
  logic signed [MOD_W-1:0] mod_clip;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire                    rise_en    = ~phase;
  wire                    fall_en    = phase;
  wire [CNT_W:0]          period     = period_cyc(ratio);
  wire [CNT_W:0]          half       = {1'b0, period[CNT_W:1]};
  wire [CNT_W:0]          clr_sum    = {1'b0, SET_PT} + half;
  wire [CNT_W-1:0]        clr_pt     = (clr_sum >= period) ? CNT_W'(clr_sum - period)
                                                           : clr_sum[CNT_W-1:0];
  wire                    cnt_wrap   = {1'b0, cnt} == (period - 5'h01);
  wire [CNT_W-1:0]        next_cnt   = cnt_wrap ? CNT_RST : cnt + 4'h1;
  wire                    strobe_set = running && (cnt == SET_PT);
  wire                    strobe_clr = running && (cnt == clr_pt);
  wire                    start      = ~running & fall_en;
  wire                    mod_over;
  wire signed [MOD_W-1:0] mod_clip_now;
  wire                    filt_over;
  wire signed [SAMPLE_W-1:0] filt_clip;

  dcr_ovr_det #(
    .IN_W  (MOD_W),
    .OUT_W (MOD_W),
    .LIMIT (MOD_LIMIT)
  ) u_mod_det (
    .data_in  (MOD_DATA_IN),
    .over_out (mod_over),
    .clip_out (mod_clip_now)
  );

  dcr_ovr_det #(
    .IN_W  (FILT_W),
    .OUT_W (SAMPLE_W),
    .LIMIT (FULL_SCALE)
  ) u_filt_det (
    .data_in  (FILT_DATA_IN),
    .over_out (filt_over),
    .clip_out (filt_clip)
  );

  // ----------------------------------------------------------------
  // Converter clock phase and ratio latch
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin // RQ1
    if (!RSTN_IN) begin
      phase <= 1'b0;
      ratio <= RATIO_RST;
    end else begin
      phase <= ~phase;
      if (fall_en) begin
        ratio <= encode_mode(MODE_CMP_IN); // RQ16 RQ17
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider and valid strobe
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      running <= 1'b0; // RQ3
      cnt     <= CNT_RST; // RQ3
      strobe  <= 1'b0; // RQ2
    end else begin
      if (start) begin
        running <= 1'b1; // RQ5
        cnt     <= CNT_RST;
      end else if (running) begin
        cnt <= next_cnt; // RQ21
      end
      if (strobe_set) begin
        strobe <= 1'b1; // RQ5 RQ19
      end else if (strobe_clr) begin
        strobe <= 1'b0; // RQ19
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample and flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sample <= SAMPLE_RST;
    end else if (strobe_set) begin
      sample <= '{over: filt_over, data: filt_clip}; // RQ14 RQ18 RQ20
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mod_clip     <= '0; // RQ3
      mod_ovr_pipe <= '0;
      ovr_flag     <= 1'b0;
    end else begin
      if (rise_en) begin
        mod_clip <= mod_clip_now; // RQ12
      end
      mod_ovr_pipe[0] <= rise_en & mod_over; // RQ12
      if (fall_en) begin
        ovr_flag <= mod_ovr_pipe[OVR_STAGES-1] | sample.over; // RQ10 RQ13 RQ15
      end
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < OVR_STAGES; gi++) begin : g_ovr_pipe
      always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          mod_ovr_pipe[gi] <= 1'b0;
        end else begin
          mod_ovr_pipe[gi] <= mod_ovr_pipe[gi-1]; // RQ13
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CONV_CLK_OUT            = phase;
  assign MOD_RST_OUT             = ~RSTN_IN; // RQ3
  // Filter state is only frozen, never cleared
  assign FILT_CLK_EN_OUT         = running & fall_en; // RQ2 RQ6
  assign MOD_CLIP_OUT            = mod_clip;
  assign OUTPUT_VALID_STROBE_OUT = strobe;
  assign SAMPLE_OUTPUT_BITS_OUT  = sample.data;
  assign SAMPLE_OE_OUT           = ~CS_N_IN & READ_IN;
  assign OVERRANGE_FLAG_OUT      = ovr_flag;
  assign RATIO_OUT               = ratio;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CNT_W:0] gap;
  logic           gap_ok;
  wire            ratio_move = fall_en && (encode_mode(MODE_CMP_IN) != ratio);

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (strobe_set) begin
      gap    <= 5'h01;
      gap_ok <= ~ratio_move;
    end else begin
      gap_ok <= gap_ok & ~ratio_move;
      if (gap != 5'h1F) begin
        gap <= gap + 5'h01;
      end
    end
  end

  chk_reset_quiet: assert property ( // RQ2
    @(posedge CORE_CLK_IN) !RSTN_IN |-> !strobe && !FILT_CLK_EN_OUT)
    else $error("strobe or filter clock active in reset");

  chk_reset_clears: assert property ( // RQ3
    @(posedge CORE_CLK_IN) !RSTN_IN |-> MOD_RST_OUT && cnt == CNT_RST && !running)
    else $error("dividers or modulator not held cleared");

  chk_restart_strobe: assert property ( // RQ5
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $rose(running) |-> $past(fall_en) ##2 $rose(strobe))
    else $error("strobe did not rise two cycles after restart");

  chk_strobe_period: assert property ( // RQ21
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (strobe_set && gap_ok && $stable(ratio)) |-> gap == period)
    else $error("strobe period does not match ratio");

  chk_sample_edge: assert property ( // RQ18
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $changed(SAMPLE_OUTPUT_BITS_OUT) |-> $rose(strobe))
    else $error("sample changed away from strobe rise");

  chk_mod_ovr_delay: assert property ( // RQ13
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rise_en && mod_over) |-> ##8 OVERRANGE_FLAG_OUT)
    else $error("modulator overrange not flagged on time");

  chk_flag_cadence: assert property ( // RQ10
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $changed(OVERRANGE_FLAG_OUT) |-> $past(fall_en))
    else $error("overrange flag changed off the falling edge");

  chk_filt_or: assert property ( // RQ15
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (fall_en && sample.over) |=> OVERRANGE_FLAG_OUT)
    else $error("filter overrange missing from flag");

  chk_mode_latch: assert property ( // RQ17
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $changed(ratio) |-> $past(fall_en))
    else $error("ratio changed off the falling edge");

  chk_mod_clip: assert property ( // RQ12
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    MOD_CLIP_OUT <= MOD_LIMIT && MOD_CLIP_OUT >= -MOD_LIMIT)
    else $error("modulator data beyond clip limit");

endmodule : dcr_ctrl

`default_nettype wire

// >>> logic/dcr_pkg.sv
// Constants and types for the decimating converter reset / overrange control.
// Assumes one 100 MHz core clock; the converter clock is half that rate.
package dcr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STROBE_DLY_NS    = 15;
  // Least delay, rounded up to whole core cycles
  localparam int STROBE_DLY_CYC   = (STROBE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Modulator detector lag: 3 1/2 converter periods, counted in half periods
  localparam int OVR_MOD_DLY_HALF = 7;
  localparam int OVR_STAGES       = OVR_MOD_DLY_HALF;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int SAMPLE_W   = 16;
  localparam int MOD_W      = 18;
  localparam int FILT_W     = 18;
  localparam int CNT_W      = 4;
  localparam int FULL_SCALE = 32767;
  localparam int MOD_LIMIT  = (FULL_SCALE * 103) / 100;

  localparam logic [CNT_W-1:0] CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0] SET_PT   = CNT_W'(STROBE_DLY_CYC - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCR_X1 = 2'b00,
    DCR_X2 = 2'b01,
    DCR_X4 = 2'b10,
    DCR_X8 = 2'b11
  } dcr_ratio_e;

  localparam dcr_ratio_e RATIO_RST = DCR_X8;

  typedef struct packed {
    logic                       over;
    logic signed [SAMPLE_W-1:0] data;
  } dcr_sample_s;

  localparam dcr_sample_s SAMPLE_RST = '{over: 1'b0, data: 16'h0000};

endpackage : dcr_pkg

// >>> logic/dcr_ovr_det.sv
// Range detector with hard clip to a symmetric limit.
// Purely combinational; the caller registers its outputs.
`timescale 1ns/10ps
`default_nettype none

module dcr_ovr_det #(
  parameter int IN_W  = 18,
  parameter int OUT_W = 18,
  parameter int LIMIT = 32767
) (
  // Data in
  input  wire logic signed [IN_W-1:0]  data_in,
  // Results
  output logic                         over_out,
  output logic signed [OUT_W-1:0]      clip_out
);

  wire over_hi = data_in > LIMIT;
  wire over_lo = data_in < -LIMIT;

  assign over_out = over_hi | over_lo;
  assign clip_out = over_hi ? OUT_W'(LIMIT) :
                    over_lo ? OUT_W'(-LIMIT) : data_in[OUT_W-1:0];

endmodule : dcr_ovr_det

`default_nettype wire

// >>> test/dcr_host_model.sv
// Host-side model: latches sample words and the overrange flag.
// Assumes the bench drives chip select and read for the device.
`timescale 1ns/10ps
`default_nettype none

module dcr_host_model
  import dcr_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rstn_in,
  // Device outputs
  input  wire logic                       strobe_in,
  input  wire logic signed [SAMPLE_W-1:0] bits_in,
  input  wire logic                       oe_in,
  input  wire logic                       flag_in,
  input  wire logic                       conv_clk_in,
  input  wire logic [1:0]                 ratio_in,
  // Captured values
  output logic signed [SAMPLE_W-1:0]      word_out,
  output logic                            flag_out,
  output logic                            settled_out
);
  logic signed [SAMPLE_W-1:0] bus;
  logic signed [SAMPLE_W-1:0] last = '0;
  int                         n_seen;
  int                         flush;

  // Released bus shows the inverse of the last value
  assign bus = oe_in ? bits_in : ~last;
  assign flush = (ratio_in == 2'h3) ? 321 : (ratio_in == 2'h2) ? 108 :
                 (ratio_in == 2'h1) ? 23 : 0;
  assign settled_out = (n_seen >= flush);

  // Words latched on the strobe fall, well after the data change
  always @(negedge strobe_in or negedge rstn_in) begin
    if (!rstn_in) begin
      n_seen <= 0;
    end else begin
      if (settled_out) begin
        word_out <= bus;
      end
      n_seen <= n_seen + 1;
    end
  end

  always @(posedge clk_in) begin
    last <= bus;
    if (conv_clk_in) begin
      flag_out <= flag_in;
    end
  end
endmodule : dcr_host_model
`default_nettype wire

// >>> test/decimating_adc_reset_overrange_ctrl_test.sv
// Self-checking bench for the converter reset / overrange control.
// Assumes a 100 MHz core clock and the host model on the sample side.
`timescale 1ns/10ps
`default_nettype none

module decimating_adc_reset_overrange_ctrl_test;
  import dcr_pkg::*;
  localparam int DLY = 2;
  logic clk = 1'b0, rstn = 1'b1, cs_n = 1'b0, read = 1'b1;
  logic [2:0] mode_cmp = 3'h0;
  logic signed [MOD_W-1:0] mod_data = '0;
  logic signed [FILT_W-1:0] filt_data = '0;
  logic conv_clk, mod_rst, filt_en, strobe, oe, flag, h_flag, h_settled;
  logic signed [MOD_W-1:0] mod_clip;
  logic signed [SAMPLE_W-1:0] bits, h_word;
  logic [1:0] ratio;
  int fail_count = 0, n_compared = 0, cyc = 0, en_cnt = 0;
  dcr_sample_s exp_q[$];

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (filt_en) en_cnt <= en_cnt + 1;

  dcr_ctrl dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .MODE_CMP_IN(mode_cmp),
    .MOD_DATA_IN(mod_data), .FILT_DATA_IN(filt_data), .CS_N_IN(cs_n), .READ_IN(read),
    .CONV_CLK_OUT(conv_clk), .MOD_RST_OUT(mod_rst), .FILT_CLK_EN_OUT(filt_en),
    .MOD_CLIP_OUT(mod_clip), .OUTPUT_VALID_STROBE_OUT(strobe),
    .SAMPLE_OUTPUT_BITS_OUT(bits), .SAMPLE_OE_OUT(oe), .OVERRANGE_FLAG_OUT(flag),
    .RATIO_OUT(ratio));
  dcr_host_model host (.clk_in(clk), .rstn_in(rstn), .strobe_in(strobe), .bits_in(bits),
    .oe_in(oe), .flag_in(flag), .conv_clk_in(conv_clk), .ratio_in(ratio),
    .word_out(h_word), .flag_out(h_flag), .settled_out(h_settled));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask : tick

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  function automatic dcr_sample_s clip(input int v);
    clip.over = (v > FULL_SCALE) || (v < -FULL_SCALE);
    clip.data = (v > FULL_SCALE) ? SAMPLE_W'(FULL_SCALE) :
                (v < -FULL_SCALE) ? SAMPLE_W'(-FULL_SCALE) : SAMPLE_W'(v);
  endfunction : clip

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic do_reset(input int hold);
    rstn = 1'b0;
    #1;
    check({strobe, filt_en, conv_clk, mod_rst}, 32'h1, "reset outputs");
    tick(hold);
    check({flag, ratio}, 32'h3, "reset flag and ratio");
    rstn = 1'b1;
    tick(3);
    check(strobe, 1'b0, "strobe before restart");
    tick(1);
    check(strobe, 1'b1, "strobe after restart");
    $display("Test reset done");
  endtask : do_reset

  task automatic sample_run(input int n);
    int v;
    for (int i = 0; i < 400 && h_settled !== 1'b1; i++) @(negedge strobe);
    repeat (n) begin
      @(negedge strobe);
      #DLY;
      v = int'($urandom_range(80000)) - 40000;
      filt_data = FILT_W'(v);
      exp_q.push_back(clip(v));
    end
    @(negedge strobe);
    #DLY;
    $display("Test samples done");
  endtask : sample_run

  task automatic mod_over(input int v, input int clipped);
    filt_data = '0;
    tick(34);
    repeat (2) if (conv_clk !== 1'b0) tick(1);
    mod_data = MOD_W'(v);
    tick(1);
    check(mod_clip, MOD_W'(clipped), "modulator clip");
    tick(1);
    mod_data = '0;
    tick(5);
    check(flag, 1'b0, "flag too early");
    tick(1);
    check(flag, 1'b1, "flag at 3.5 periods");
    tick(2);
    check(flag, 1'b0, "flag next period");
    $display("Test modulator overrange done");
  endtask : mod_over

  task automatic ratio_sweep;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    logic [1:0] sels [5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h3};
    int r [5] = '{8, 2, 4, 1, 8};
    int t0, t1, t2, e0;
    for (int i = 0; i < 5; i++) begin
      mode_cmp = codes[i];
      tick(40);
      check(ratio, sels[i], "ratio select");
      cs_n = 1'($urandom_range(1));
      read = 1'($urandom_range(1));
      #1;
      check(oe, !cs_n && read, "output enable");
      @(posedge strobe) #1 t0 = cyc;
      e0 = en_cnt;
      @(negedge strobe) #1 t1 = cyc;
      @(posedge strobe) #1 t2 = cyc;
      check(t1 - t0, r[i], "strobe high time");
      check(t2 - t0, 2 * r[i], "strobe period");
      check(en_cnt - e0, r[i], "filter clock pulses");
      #1;
    end
    mode_cmp = 3'h0;
    cs_n = 1'b0;
    read = 1'b1;
    tick(40);
    $display("Test ratio sweep done");
  endtask : ratio_sweep

  // Word and flag of each sample, checked at the strobe fall
  always @(negedge strobe) begin
    dcr_sample_s e;
    #1;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(h_word, e.data, "sample word");
      check(h_flag, e.over, "sample overrange");
    end
  end

  initial begin
    void'($urandom(68));
    #DLY;
    do_reset(20);
    sample_run(24);
    mod_over(40000, 33750);
    mod_over(-40000, -33750);
    ratio_sweep();
    do_reset(2);
    sample_run(8);
    stop_test();
  end

  // Run needs about 11k cycles; allow well over double
  initial begin
    #300us;
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    stop_test();
  end
endmodule : decimating_adc_reset_overrange_ctrl_test
`default_nettype wire
